// File: fetc_pkg.sv
/*
 * Shared constants for the 100 Mb/s coding path: timing, code groups, scrambler, states.
 * Assumes a 100 MHz core clock and a line bit clock that is much slower than it.
 */
package fetc_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 160;
    localparam int BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // framing and buffering
    localparam int GROUP_BITS    = 5;
    localparam int FIFO_DEPTH    = 4;
    localparam int TX_WORD_W     = 6;   // {tx_er, tx_en, nibble}
    localparam int TX_EN_BIT     = 4;
    localparam int TX_ER_BIT     = 5;
    // scrambler, x^11 + x^9 + 1
    localparam int LFSR_W        = 11;
    localparam int LFSR_TAP_A    = 10;
    localparam int LFSR_TAP_B    = 8;
    localparam int SCR_PERIOD    = 2047;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;
    localparam int LOCK_ONES     = 40;  // matched idle bits before lock
    // control code groups
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0d;
    localparam logic [4:0] CG_R    = 5'h07;
    localparam logic [4:0] CG_H    = 5'h04;
    localparam logic [9:0] CG_JK   = 10'h311;
    // line levels {pos, neg}
    localparam logic [1:0] MLT_ZERO = 2'h0;
    localparam logic [1:0] MLT_POS  = 2'h2;
    localparam logic [1:0] MLT_NEG  = 2'h1;

    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_J    = 6'h02,
        TX_K    = 6'h04,
        TX_DATA = 6'h08,
        TX_T    = 6'h10,
        TX_R    = 6'h20
    } fetc_tx_state_type;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'h1,
        RX_FRAME = 2'h2
    } fetc_rx_state_type;
endpackage

// File: fetc_coding_path.sv
/*
 * 100 Mb/s coding path: transmit FIFO, 4B/5B, scrambler, NRZI, MLT-3 and the reverse chain.
 * Assumes the MAC nibble side on clock_in and a slow line bit clock sampled by clock_in.
 */
`timescale 1ns/1ns

// small first-in first-out buffer, depth a power of two
module fetc_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             push, pop;

    // pointer and fill bookkeeping
    always_comb begin
        in_ready_out  = (cnt_q != CW'(DEPTH));
        out_valid_out = (cnt_q != '0);
        out_data_out  = mem_q[rd_q];
        push = in_valid_in && in_ready_out && ce_in;
        pop  = out_valid_out && out_ready_in && ce_in;
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
endmodule

module fetc_coding_path
    import fetc_pkg::*;
#(
    parameter int BIT_DIV = fetc_pkg::BIT_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    input  wire logic [3:0] tx_data_in,
    input  wire logic       tx_en_in,
    input  wire logic       tx_er_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    output logic      [1:0] tx_mlt_out,
    input  wire logic       rx_line_clk_in,
    input  wire logic [1:0] rx_mlt_in,
    output logic      [3:0] rx_data_out,
    output logic            rx_dv_out,
    output logic            rx_er_out,
    output logic            rx_valid_out,
    output logic            rx_lock_out
);
    import fetc_pkg::*;
    localparam int DW = $clog2(BIT_DIV);

    function automatic logic [4:0] enc(input logic [3:0] n);
        logic [4:0] c;
        c = CG_H;
        unique case (n)
            4'h0: c = 5'h1e; 4'h1: c = 5'h09; 4'h2: c = 5'h14; 4'h3: c = 5'h15;
            4'h4: c = 5'h0a; 4'h5: c = 5'h0b; 4'h6: c = 5'h0e; 4'h7: c = 5'h0f;
            4'h8: c = 5'h12; 4'h9: c = 5'h13; 4'ha: c = 5'h16; 4'hb: c = 5'h17;
            4'hc: c = 5'h1a; 4'hd: c = 5'h1b; 4'he: c = 5'h1c; 4'hf: c = 5'h1d;
        endcase
        return c;
    endfunction

    // returns {ok, nibble}; ok low for any non-data group
    function automatic logic [4:0] dec(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc(4'(i)) == c) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // transmit buffer between MAC and coder
    logic [TX_WORD_W-1:0] fifo_word;
    logic                 fifo_valid, fifo_pop;
    fetc_fifo #(.WIDTH(TX_WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .ce_in         (ce_in),
        .in_data_in    ({tx_er_in, tx_en_in, tx_data_in}),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .out_data_out  (fifo_word),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    // transmit state
    fetc_tx_state_type tx_state_q, tx_state_d;
    logic [DW-1:0]  tx_div_q, tx_div_d;
    logic [2:0]     tx_bit_q, tx_bit_d;
    logic [4:0]     tx_sh_q, tx_sh_d;
    logic [10:0]    tx_lfsr_q, tx_lfsr_d;
    logic [10:0]    tx_bits_q, tx_bits_d;
    logic           tx_nrzi_q, tx_nrzi_d;
    logic [1:0]     tx_ph_q, tx_ph_d;
    logic [1:0]     tx_mlt_q, tx_mlt_d;
    logic           tx_tick, tx_boundary, tx_key, tx_scr, fifo_data;

    // bit divider, group framing, coding, scrambling and line levels
    always_comb begin
        tx_tick     = (tx_div_q == DW'(BIT_DIV - 1));
        tx_boundary = tx_tick && (tx_bit_q == 3'(GROUP_BITS - 1));
        fifo_data   = fifo_valid && fifo_word[TX_EN_BIT];
        tx_div_d    = tx_tick ? '0 : tx_div_q + 1'b1;
        tx_state_d  = tx_state_q;
        tx_bit_d    = tx_bit_q;
        tx_sh_d     = tx_sh_q;
        tx_lfsr_d   = tx_lfsr_q;
        tx_bits_d   = tx_bits_q;
        tx_nrzi_d   = tx_nrzi_q;
        tx_ph_d     = tx_ph_q;
        tx_mlt_d    = tx_mlt_q;
        fifo_pop    = 1'b0;
        tx_key      = tx_lfsr_q[LFSR_TAP_A] ^ tx_lfsr_q[LFSR_TAP_B];
        tx_scr      = tx_sh_q[GROUP_BITS-1] ^ tx_key;
        if (tx_tick) begin
            tx_lfsr_d = {tx_lfsr_q[9:0], tx_key};
            tx_bits_d = (tx_bits_q == 11'(SCR_PERIOD - 1)) ? '0 : tx_bits_q + 1'b1;
            tx_nrzi_d = tx_nrzi_q ^ tx_scr;
            if (tx_scr) begin
                tx_ph_d = tx_ph_q + 1'b1;
            end
            unique case (tx_ph_d)
                2'h1:    tx_mlt_d = MLT_POS;
                2'h3:    tx_mlt_d = MLT_NEG;
                default: tx_mlt_d = MLT_ZERO;
            endcase
            tx_bit_d = tx_bit_q + 1'b1;
            tx_sh_d  = {tx_sh_q[3:0], 1'b0};
        end
        if (tx_boundary) begin
            tx_bit_d = '0;
            unique case (tx_state_q)
                TX_IDLE: begin
                    // stray words without tx_en are dropped between frames
                    fifo_pop   = fifo_valid && !fifo_word[TX_EN_BIT];
                    tx_state_d = fifo_data ? TX_J : TX_IDLE;
                    tx_sh_d    = fifo_data ? CG_J : CG_IDLE;
                end
                TX_J: begin
                    tx_state_d = TX_K;
                    tx_sh_d    = CG_K;
                end
                TX_K, TX_DATA: begin
                    // an empty buffer mid-frame ends the frame: MAC must keep up
                    fifo_pop   = fifo_data;
                    tx_state_d = fifo_data ? TX_DATA : TX_T;
                    tx_sh_d    = !fifo_data ? CG_T :
                                 fifo_word[TX_ER_BIT] ? CG_H : enc(fifo_word[3:0]);
                end
                TX_T: begin
                    tx_state_d = TX_R;
                    tx_sh_d    = CG_R;
                end
                TX_R: begin
                    tx_state_d = TX_IDLE;
                    tx_sh_d    = CG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tx_state_q <= TX_IDLE;
            tx_div_q   <= '0;
            tx_bit_q   <= '0;
            tx_sh_q    <= CG_IDLE;
            tx_lfsr_q  <= LFSR_SEED;
            tx_bits_q  <= '0;
            tx_nrzi_q  <= 1'b0;
            tx_ph_q    <= '0;
            tx_mlt_q   <= MLT_ZERO;
        end else if (ce_in) begin
            tx_state_q <= tx_state_d;
            tx_div_q   <= tx_div_d;
            tx_bit_q   <= tx_bit_d;
            tx_sh_q    <= tx_sh_d;
            tx_lfsr_q  <= tx_lfsr_d;
            tx_bits_q  <= tx_bits_d;
            tx_nrzi_q  <= tx_nrzi_d;
            tx_ph_q    <= tx_ph_d;
            tx_mlt_q   <= tx_mlt_d;
        end
    end
    assign tx_mlt_out = tx_mlt_q;

    // receive state
    fetc_rx_state_type rx_state_q, rx_state_d;
    logic [2:0]  rx_clk_s_q;   // [0] first stage, read only by [1]
    logic [1:0]  rx_lvl_s1_q, rx_lvl_s2_q, rx_prev_q, rx_prev_d;
    logic        rx_nrzi_q, rx_nrzi_d, rx_lock_q, rx_lock_d;
    logic [10:0] rx_lfsr_q, rx_lfsr_d;
    logic [5:0]  rx_ones_q, rx_ones_d;
    logic [9:0]  rx_sh_q, rx_sh_d;
    logic [2:0]  rx_cnt_q, rx_cnt_d;
    logic [3:0]  rx_data_q, rx_data_d;
    logic        rx_dv_q, rx_dv_d, rx_er_q, rx_er_d, rx_valid_q, rx_valid_d;
    logic        rx_edge, rx_nrz, rx_pred, rx_bit, rx_bad;
    logic [4:0]  rx_dec;

    // line pins cross into clock_in through two flops each
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_clk_s_q  <= '0;
            rx_lvl_s1_q <= MLT_ZERO;
            rx_lvl_s2_q <= MLT_ZERO;
        end else if (ce_in) begin
            rx_clk_s_q  <= {rx_clk_s_q[1:0], rx_line_clk_in};
            rx_lvl_s1_q <= rx_mlt_in;
            rx_lvl_s2_q <= rx_lvl_s1_q;
        end
    end

    // recovery, descrambling, alignment and decoding
    always_comb begin
        rx_edge    = rx_clk_s_q[1] && !rx_clk_s_q[2];
        rx_prev_d  = rx_prev_q;
        rx_nrzi_d  = rx_nrzi_q;
        rx_lock_d  = rx_lock_q;
        rx_lfsr_d  = rx_lfsr_q;
        rx_ones_d  = rx_ones_q;
        rx_sh_d    = rx_sh_q;
        rx_cnt_d   = rx_cnt_q;
        rx_state_d = rx_state_q;
        rx_data_d  = rx_data_q;
        rx_dv_d    = rx_dv_q;
        rx_er_d    = rx_er_q;
        rx_valid_d = 1'b0;
        rx_nrz     = 1'b0;
        rx_bit     = 1'b0;
        rx_pred    = rx_lfsr_q[LFSR_TAP_A] ^ rx_lfsr_q[LFSR_TAP_B];
        rx_dec     = dec(rx_sh_d[4:0]);
        rx_bad     = 1'b0;
        if (rx_edge) begin
            rx_prev_d = rx_lvl_s2_q;
            rx_nrzi_d = rx_nrzi_q ^ (rx_lvl_s2_q != rx_prev_q);
            rx_nrz    = rx_nrzi_d ^ rx_nrzi_q;
            rx_bit    = rx_nrz ^ rx_pred;
            if (!rx_lock_q) begin
                // idle is all ones, so the inverted line bit is the key
                rx_lfsr_d = {rx_lfsr_q[9:0], !rx_nrz};
                rx_ones_d = rx_bit ? rx_ones_q + 1'b1 : '0;
                rx_lock_d = rx_bit && (rx_ones_q == 6'(LOCK_ONES - 1));
                rx_sh_d   = rx_sh_q;
            end else begin
                rx_lfsr_d = {rx_lfsr_q[9:0], rx_pred};
                rx_sh_d   = {rx_sh_q[8:0], rx_bit};
                rx_dec    = dec(rx_sh_d[4:0]);
                unique case (rx_state_q)
                    RX_HUNT: begin
                        if (rx_sh_d == CG_JK) begin
                            rx_state_d = RX_FRAME;
                            rx_cnt_d   = '0;
                            rx_dv_d    = 1'b1;
                            rx_er_d    = 1'b0;
                        end
                    end
                    RX_FRAME: begin
                        rx_cnt_d = rx_cnt_q + 1'b1;
                        if (rx_cnt_q == 3'(GROUP_BITS - 1)) begin
                            rx_cnt_d   = '0;
                            rx_valid_d = (rx_sh_d[4:0] != CG_T);
                            rx_data_d  = rx_dec[3:0];
                            rx_bad     = !rx_dec[4];
                            rx_er_d    = rx_bad && (rx_sh_d[4:0] != CG_T);
                            if (rx_sh_d[4:0] == CG_T || rx_sh_d[4:0] == CG_IDLE) begin
                                rx_state_d = RX_HUNT;
                                rx_dv_d    = 1'b0;
                            end
                        end
                    end
                    default: rx_state_d = RX_HUNT;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_state_q <= RX_HUNT;
            rx_prev_q  <= MLT_ZERO;
            rx_nrzi_q  <= 1'b0;
            rx_lock_q  <= 1'b0;
            rx_lfsr_q  <= '0;
            rx_ones_q  <= '0;
            rx_sh_q    <= '0;
            rx_cnt_q   <= '0;
            rx_data_q  <= '0;
            rx_dv_q    <= 1'b0;
            rx_er_q    <= 1'b0;
            rx_valid_q <= 1'b0;
        end else if (ce_in) begin
            rx_state_q <= rx_state_d;
            rx_prev_q  <= rx_prev_d;
            rx_nrzi_q  <= rx_nrzi_d;
            rx_lock_q  <= rx_lock_d;
            rx_lfsr_q  <= rx_lfsr_d;
            rx_ones_q  <= rx_ones_d;
            rx_sh_q    <= rx_sh_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_data_q  <= rx_data_d;
            rx_dv_q    <= rx_dv_d;
            rx_er_q    <= rx_er_d;
            rx_valid_q <= rx_valid_d;
        end
    end
    assign rx_data_out  = rx_data_q;
    assign rx_dv_out    = rx_dv_q;
    assign rx_er_out    = rx_er_q;
    assign rx_valid_out = rx_valid_q;
    assign rx_lock_out  = rx_lock_q;

    // checks on the coding path
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    a_pop_on_group:   assert property (fifo_pop && ce_in |-> tx_boundary)
        else $error("fifo popped off a group boundary");
    a_ssd_order:      assert property (ce_in && tx_boundary && tx_state_q == TX_J |=> tx_state_q == TX_K)
        else $error("J not followed by K");
    a_mlt_step:       assert property (ce_in && tx_tick && tx_scr |=> tx_ph_q == $past(tx_ph_q) + 2'h1)
        else $error("line level did not advance on a one");
    a_mlt_no_jump:    assert property (!(tx_mlt_q == MLT_NEG && $past(tx_mlt_q) == MLT_POS))
        else $error("line jumped from plus to minus");
    a_lfsr_alive:     assert property (tx_lfsr_q != '0)
        else $error("scrambler stuck at zero");
    a_scr_period:     assert property (tx_bits_q == '0 |-> tx_lfsr_q == LFSR_SEED)
        else $error("scrambler period is not 2047");
    a_dv_locked:      assert property (rx_dv_q |-> rx_lock_q)
        else $error("frame data without descrambler lock");
    a_lock_on_idle:   assert property ($rose(rx_lock_q) |-> $past(rx_ones_q) == 6'(LOCK_ONES - 1))
        else $error("lock without enough idle");
    a_nibble_spacing: assert property (rx_valid_q |=> !rx_valid_q [*8])
        else $error("receive nibbles too close");
    a_bad_group:      assert property (ce_in && rx_edge && rx_bad && rx_sh_d[4:0] != CG_T |=> rx_er_q && rx_valid_q)
        else $error("invalid group not flagged");

    c_tx_frame: cover property (tx_state_q == TX_DATA ##1 tx_state_q == TX_T);
    c_rx_lock:  cover property ($rose(rx_lock_q));
    c_rx_data:  cover property (rx_valid_q && !rx_er_q);
    c_rx_error: cover property (rx_valid_q && rx_er_q);
endmodule

// File: fetc_line_partner.sv
/*
 * Cable-side partner for the coding path: a free-running line bit clock and
 * a relay that hands every transmitted level back to the receive input.
 * Assumes tx_mlt_out advances once per 160 ns line bit, at any phase.
 */
`timescale 1ns/1ns

module fetc_line_partner #(
    parameter int HALF_NS  = fetc_pkg::BIT_TIME_NS / 2,
    parameter int PHASE_NS = 3
) (
    input  wire logic [1:0] tx_mlt_in,
    output logic            line_clk_out,
    output logic      [1:0] mlt_out
);
    import fetc_pkg::*;

    // idle keeps the line busy, so the bit clock runs between frames too
    initial begin
        line_clk_out = 1'b0;
        mlt_out      = MLT_ZERO;
        #(PHASE_NS);
        forever #(HALF_NS) line_clk_out = ~line_clk_out;
    end

    // same rate as the transmitter, so each bit is caught exactly once;
    // updating on the falling edge keeps the level steady at the sampling edge
    always @(negedge line_clk_out) begin
        mlt_out <= tx_mlt_in;
    end
endmodule

// File: fetc_coding_path_tb_top.sv
/*
 * Self-checking bench for the coding path: reset, idle line, lock, frames.
 * Assumes the line partner loops the transmitted levels back to the receiver.
 */
`timescale 1ns/1ns

module fetc_coding_path_tb_top;
    import fetc_pkg::*;

    localparam int BIT_DIV = 16;  // full rate, matches the 160 ns link clock
    localparam int GROUP_CYC = GROUP_BITS * BIT_DIV;

    logic       clock_in;
    logic       reset_in;
    logic       ce_in;
    logic [3:0] tx_data_in;
    logic       tx_en_in;
    logic       tx_er_in;
    logic       tx_valid_in;
    logic       tx_ready_out;
    logic [1:0] tx_mlt_out;
    logic       rx_line_clk_in;
    logic [1:0] rx_mlt_in;
    logic [3:0] rx_data_out;
    logic       rx_dv_out;
    logic       rx_er_out;
    logic       rx_valid_out;
    logic       rx_lock_out;
    int         n_errors;
    int         checks_done;
    logic [5:0] rxq[$];  // {dv, er, nibble} per delivered group

    fetc_coding_path #(.BIT_DIV(BIT_DIV)) u_dut (
        .clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in),
        .tx_data_in(tx_data_in), .tx_en_in(tx_en_in), .tx_er_in(tx_er_in),
        .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .tx_mlt_out(tx_mlt_out),
        .rx_line_clk_in(rx_line_clk_in), .rx_mlt_in(rx_mlt_in), .rx_data_out(rx_data_out),
        .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out), .rx_valid_out(rx_valid_out),
        .rx_lock_out(rx_lock_out)
    );

    fetc_line_partner u_partner (
        .tx_mlt_in(tx_mlt_out), .line_clk_out(rx_line_clk_in), .mlt_out(rx_mlt_in)
    );

    // core clock
    initial begin
        clock_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;
    end

    // one-cycle pulse, read mid-cycle where it has settled
    always @(negedge clock_in) begin
        if (rx_valid_out === 1'b1) begin
            rxq.push_back({rx_dv_out, rx_er_out, rx_data_out});
        end
    end

    // comparisons
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // offer one word and hold it until taken; valid stays up for the next word
    task automatic push(input logic [3:0] d, input logic en, input logic er);
        int t;
        tx_data_in  = d;
        tx_en_in    = en;
        tx_er_in    = er;
        tx_valid_in = 1'b1;
        t = 0;
        // ready is settled here, so it tells whether the next edge takes the word
        while (tx_ready_out !== 1'b1 && t < 2000) begin
            @(posedge clock_in);
            #1;
            t++;
        end
        chk_flag(tx_ready_out, 1'b1, "word taken");
        @(posedge clock_in);
        #1;
    endtask

    task automatic tx_stop();
        tx_valid_in = 1'b0;
        @(posedge clock_in);
        #1;
    endtask

    // wait until n nibbles arrived and the frame closed
    task automatic wait_frame(input int n);
        int t;
        t = 0;
        while ((rxq.size() < n || rx_dv_out !== 1'b0) && t < GROUP_CYC * (n + 12)) begin
            @(posedge clock_in);
            #1;
            t++;
        end
        chk_val(16'(rxq.size()), 16'(n), "nibbles received");
    endtask

    task automatic t_reset();
        repeat (12) @(posedge clock_in);
        #1;
        chk_val({5'h00, tx_ready_out, tx_mlt_out, rx_data_out, rx_dv_out, rx_er_out,
                 rx_valid_out, rx_lock_out}, 16'h0400, "reset outputs");
        reset_in = 1'b0;
        $display("test reset done");
    endtask

    // idle line: legal MLT-3 steps, key recurrence and period, receiver lock
    task automatic t_idle_line();
        logic [1:0]  prev;
        logic [1:0]  last_nz;
        logic [1:0]  lvl;
        logic [1:0]  want;
        logic [10:0] hist;
        logic [10:0] snap;
        logic        key;
        int          bad;
        int          period;
        prev    = MLT_ZERO;
        last_nz = MLT_NEG;
        hist    = 11'h000;
        snap    = 11'h000;
        bad     = 0;
        period  = 0;
        for (int n = 0; n < SCR_PERIOD + 23; n++) begin
            @(posedge rx_line_clk_in);
            lvl = rx_mlt_in;
            if (lvl !== prev) begin
                want = (prev != MLT_ZERO) ? MLT_ZERO : ((last_nz == MLT_POS) ? MLT_NEG : MLT_POS);
                if (lvl !== want) bad++;
                if (prev != MLT_ZERO) last_nz = prev;
            end
            key = (lvl === prev);  // idle codes are all ones, so key is the inverse bit
            if (n >= LFSR_W && key !== (hist[10] ^ hist[8])) bad++;
            hist = {hist[9:0], key};
            prev = lvl;
            if (n == LFSR_W) snap = hist;
            else if (n > LFSR_W && period == 0 && hist === snap) period = n - LFSR_W;
        end
        chk_val(bad[15:0], 16'h0000, "line steps and key");
        chk_val(period[15:0], 16'(SCR_PERIOD), "key period");
        chk_flag(rx_lock_out, 1'b1, "lock on idle");
        chk_val(16'(rxq.size()), 16'h0000, "nothing delivered in idle");
        $display("test idle line done");
    endtask

    // sixteen codes back to back; fifo filled until it refuses
    task automatic t_frame();
        @(posedge clock_in);
        #1;
        rxq.delete();
        for (int i = 0; i < FIFO_DEPTH; i++) push(4'(i), 1'b1, 1'b0);
        chk_flag(tx_ready_out, 1'b0, "fifo full");
        for (int i = FIFO_DEPTH; i < 16; i++) push(4'(i), 1'b1, 1'b0);
        tx_stop();
        wait_frame(16);
        for (int i = 0; i < 16; i++) begin
            chk_val(16'(rxq[i]), {10'h000, 2'b10, 4'(i)}, "frame nibble");
        end
        $display("test frame done");
    endtask

    // a word outside a frame is dropped; an error word arrives flagged
    task automatic t_error();
        rxq.delete();
        push(4'h5, 1'b0, 1'b0);
        tx_stop();
        repeat (2 * GROUP_CYC) @(posedge clock_in);
        #1;
        push(4'ha, 1'b1, 1'b0);
        push(4'hb, 1'b1, 1'b1);
        push(4'hc, 1'b1, 1'b0);
        tx_stop();
        wait_frame(3);
        chk_val(16'(rxq[0]), 16'h002a, "first nibble");
        chk_flag(rxq[1][4], 1'b1, "error group flagged");
        chk_flag(rxq[1][5], 1'b1, "error group in frame");
        chk_val(16'(rxq[2]), 16'h002c, "after error");
        $display("test error done");
    endtask

    // main sequence
    initial begin
        n_errors    = 0;
        checks_done = 0;
        reset_in    = 1'b1;
        ce_in       = 1'b1;
        tx_data_in  = 4'h0;
        tx_en_in    = 1'b0;
        tx_er_in    = 1'b0;
        tx_valid_in = 1'b0;
        t_reset();
        t_idle_line();
        t_frame();
        t_error();
        finish_test();
    end

    // watchdog: roughly twice the idle scan plus both frames
    initial begin
        #(2 * (SCR_PERIOD + 200) * BIT_TIME_NS);
        n_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
